// ===== lmso_checker.sv
// Purpose: port timing checks for lmso_top
// Assumes: one clock domain, async low reset
// Notes:   bound from the bench top file
`timescale 1ns/1ps
module lmso_checker (
	input wire logic        clock,
	input wire logic        nrst,
	input wire logic        measValid,
	input wire logic        netFieldbus,
	input wire logic [1:0]  swOut,
	input wire logic [1:0]  swOe,
	input wire logic        irq,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	// **********
	// bus answers
	// **********
	property p_wAns;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_wAns: assert property (p_wAns) else $error("no write answer");
	property p_bHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_bHold: assert property (p_bHold) else $error("bvalid dropped");
	property p_bDone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready; endproperty
	a_bDone: assert property (p_bDone) else $error("write not closed");
	property p_rAns; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
	a_rAns: assert property (p_rAns) else $error("no read answer");
	property p_rHold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rHold: assert property (p_rHold) else $error("rdata not held");
	property p_rDone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
	a_rDone: assert property (p_rDone) else $error("read not closed");
	// **********
	// mode and outputs
	// **********
	// the mode is caught at the first edge after release, so skip the two edges after it
	property p_net; $past(nrst) && $past(nrst, 2) |-> $stable(netFieldbus); endproperty
	a_net: assert property (p_net) else $error("mode changed while running");
	// cond is taken at the edge that samples measValid, the pins move one edge later
	property p_out; $changed({swOut, swOe}) |-> $past(measValid, 2); endproperty
	a_out: assert property (p_out) else $error("output moved between evaluations");
	c_irq: cover property ($rose(irq));
	c_out: cover property ($changed(swOut));
	c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule

// ===== lmso_ctrl_in.sv
// Purpose: controller inputs reading the two switching pins
// Assumes: one pull resistor per line, chosen by the bench
// Notes:   a released pin settles to its pull level
`timescale 1ns/1ps
module lmso_ctrl_in (
	input  wire logic [1:0] swOut,
	input  wire logic [1:0] swOe,
	input  wire logic [1:0] pullUp,
	output logic      [1:0] level
);
	// low side floats when off, so only the pull gives its level
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			level[i] = swOe[i] ? swOut[i] : pullUp[i];
		end
	end
endmodule

// ===== lmso_out_stage.sv
// Purpose: one switching output, source select and drive style
// Assumes: evaluation pulse once per measurement cycle
// Notes:   output flip-flops hold between evaluations
`timescale 1ns/1ps
module lmso_out_stage
	import lmso_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              nrst,
	input  wire logic              evalEn,
	input  wire lmso_pkg::lmso_src_t src,
	input  wire lmso_pkg::lmso_drv_t drv,
	input  wire logic [3:0]        cond,
	output logic                   active,
	output logic                   pinOut,
	output logic                   pinOe
);
	logic actNxt;

	always_comb begin
		case (src) // R03
			SRC_MEAS_ERR: actNxt = cond[0];
			SRC_LOWER:    actNxt = cond[1];
			SRC_UPPER:    actNxt = cond[2];
			SRC_EITHER:   actNxt = cond[1] | cond[2]; // R07
			SRC_EDGES:    actNxt = cond[3];
			default:      actNxt = 1'b0;
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			active <= 1'b0;
			pinOut <= 1'b0;
			pinOe  <= 1'b0;
		end else if (evalEn) begin // R13
			active <= actNxt;
			case (drv) // R12
				DRV_LOW_SIDE: begin
					pinOut <= 1'b0;
					pinOe  <= actNxt;
				end
				DRV_HIGH_SIDE: begin
					pinOut <= 1'b1;
					pinOe  <= actNxt;
				end
				DRV_PUSH_PULL: begin
					pinOut <= actNxt;
					pinOe  <= 1'b1;
				end
				default: begin
					pinOut <= ~actNxt;
					pinOe  <= 1'b1;
				end
			endcase
		end
	end
endmodule

// ===== lmso_pkg.sv
// Purpose: shared constants for the limit monitor and switching outputs
// Assumes: axi4-lite slave, 32-bit data, byte addresses
// Notes:   all offsets are word aligned
package lmso_pkg;
	localparam int VAL_W = 32;
	localparam int CNT_W = 8;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_LOWER    = 8'h04;
	localparam logic [7:0] OFF_UPPER    = 8'h08;
	localparam logic [7:0] OFF_EDGES    = 8'h0c;
	localparam logic [7:0] OFF_NETMODE  = 8'h10;
	localparam logic [7:0] OFF_STATUS   = 8'h14;
	localparam logic [7:0] OFF_INTMASK  = 8'h18;
	localparam logic [7:0] OFF_OUTSTATE = 8'h1c;
	localparam logic [7:0] OFF_CMDDATA  = 8'h20;

	// control field positions
	localparam int CTRL_SRC1_LSB  = 0;
	localparam int CTRL_SRC2_LSB  = 4;
	localparam int CTRL_DRV1_LSB  = 8;
	localparam int CTRL_DRV2_LSB  = 10;
	localparam int CTRL_SEL_LSB   = 12;
	localparam int CTRL_MASTER    = 15;

	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [31:0] LOWER_RST = 32'h0000_0000;
	localparam logic [31:0] UPPER_RST = 32'h7fff_ffff;
	localparam logic [7:0]  EDGES_RST = 8'h02;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// status bits
	localparam int ST_MERR = 0;
	localparam int ST_LOW  = 1;
	localparam int ST_UP   = 2;
	localparam int ST_EDGE = 3;
	localparam int ST_CMD  = 4;

	typedef enum logic [2:0] {
		SRC_MEAS_ERR,
		SRC_NONE,
		SRC_LOWER,
		SRC_UPPER,
		SRC_EITHER,
		SRC_EDGES
	} lmso_src_t;

	typedef enum logic [1:0] {
		DRV_LOW_SIDE,
		DRV_HIGH_SIDE,
		DRV_PUSH_PULL,
		DRV_PUSH_PULL_INV
	} lmso_drv_t;

	typedef enum logic [1:0] {
		SEL_EDGE_A,
		SEL_EDGE_B,
		SEL_DIFF,
		SEL_CENTRE
	} lmso_sel_t;
endpackage

// ===== lmso_top.sv
// Purpose: limit monitoring and two switching outputs with axi4-lite registers
// Assumes: one measurement result per measValid pulse
// Notes:   network mode takes effect only at restart
//
// Functional notes
// R01 - network mode change waits for restart
// R02 - serial commands accepted in both modes
// R03 - each output picks one event source
// R04 - measurement error on too few edges
// R05 - lower flag when value below lower
// R06 - upper flag when value above upper
// R07 - either flag on any limit violation
// R08 - edge flag below expected edge count
// R09 - one value, one lower, one upper
// R10 - value chosen from program results
// R11 - mastered value used when mastering active
// R12 - four drive styles per output
// R13 - evaluate once per cycle, then hold
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
module lmso_top
	import lmso_pkg::*;
#(
	parameter int VW = VAL_W,
	parameter int CW = CNT_W
) (
	input  wire logic              clock,
	input  wire logic              nrst,
	// measurement results
	input  wire logic              measValid,
	input  wire logic              singleEdgeProg,
	input  wire logic signed [VW-1:0] edgeA,
	input  wire logic signed [VW-1:0] edgeB,
	input  wire logic signed [VW-1:0] masterOffset,
	input  wire logic [CW-1:0]     edgesFound,
	input  wire logic [CW-1:0]     edgesNeeded,
	// serial command byte stream
	input  wire logic              cmdValid,
	input  wire logic [7:0]        cmdByte,
	// network mode
	output logic                   netFieldbus,
	// switching outputs
	output logic [1:0]             swOut,
	output logic [1:0]             swOe,
	output logic                   irq,
	// axi4-lite
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);
	// ****************************************************
	// registers
	// ****************************************************
	logic [31:0]          ctrl_r;
	logic signed [VW-1:0] lower_r;
	logic signed [VW-1:0] upper_r;
	logic [CW-1:0]        edgesExp_r;
	logic                 netPending_r = 1'b0;
	logic [4:0]           status_r;
	logic [4:0]           mask_r;
	logic [7:0]           cmdData_r;
	logic [3:0]           cond_r;
	logic [1:0]           active;
	logic                 netBoot_r;

	// ****************************************************
	// axi4-lite write path
	// ****************************************************
	logic [7:0]  awAddr_r;
	logic [31:0] wData_r;
	logic [3:0]  wStrb_r;
	logic        awHave_r;
	logic        wHave_r;
	logic        doWrite;
	logic        wrHit;

	assign doWrite = awHave_r & wHave_r & ~s_axi_bvalid;

	always_comb begin
		case (awAddr_r)
			OFF_CTRL, OFF_LOWER, OFF_UPPER, OFF_EDGES,
			OFF_NETMODE, OFF_INTMASK: wrHit = 1'b1;
			default:                  wrHit = 1'b0;
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			awHave_r      <= 1'b0;
			wHave_r       <= 1'b0;
			awAddr_r      <= 8'h00;
			wData_r       <= 32'h0000_0000;
			wStrb_r       <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHave_r      <= 1'b1;
				awAddr_r      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHave_r      <= 1'b1;
				wData_r      <= s_axi_wdata;
				wStrb_r      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (doWrite) begin
				awHave_r     <= 1'b0;
				wHave_r      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	function automatic logic [31:0] mergeBytes(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ctrl_r       <= CTRL_RST;
			lower_r      <= VW'(LOWER_RST);
			upper_r      <= VW'(UPPER_RST);
			edgesExp_r   <= CW'(EDGES_RST);
			mask_r       <= 5'h00;
		end else if (doWrite) begin
			case (awAddr_r)
				OFF_CTRL:    ctrl_r <= mergeBytes(ctrl_r, wData_r, wStrb_r);
				OFF_LOWER:   lower_r <= VW'(mergeBytes(32'(lower_r), wData_r, wStrb_r));
				OFF_UPPER:   upper_r <= VW'(mergeBytes(32'(upper_r), wData_r, wStrb_r));
				OFF_EDGES:   if (wStrb_r[0]) edgesExp_r <= CW'(wData_r);
				OFF_INTMASK: if (wStrb_r[0]) mask_r <= wData_r[4:0];
				default:     ;
			endcase
		end
	end

	// the pending mode is the stored setting: it must survive a restart, so nrst leaves it alone
	always_ff @(posedge clock) begin
		if (doWrite && awAddr_r == OFF_NETMODE && wStrb_r[0]) begin
			netPending_r <= wData_r[0]; // R01
		end
	end

	// running mode is caught once after reset release and held
	logic bootDone_r;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			bootDone_r <= 1'b0;
			netBoot_r  <= 1'b0;
		end else if (!bootDone_r) begin
			bootDone_r <= 1'b1;
			netBoot_r  <= netPending_r; // R01
		end
	end
	assign netFieldbus = netBoot_r;

	// ****************************************************
	// serial commands, independent of network mode
	// ****************************************************
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cmdData_r <= 8'h00;
		end else if (cmdValid) begin
			cmdData_r <= cmdByte; // R02
		end
	end

	// ****************************************************
	// limit evaluation
	// ****************************************************
	logic signed [VW-1:0] selVal;
	logic signed [VW-1:0] monVal;
	logic [3:0]           condNxt;
	logic                 evalEn_r;
	logic [VW:0]          sumAB;

	// one extra bit so the centre of two far edges does not wrap
	assign sumAB = {edgeA[VW-1], edgeA} + {edgeB[VW-1], edgeB};

	always_comb begin
		if (singleEdgeProg) begin
			selVal = edgeA; // R10
		end else begin
			case (lmso_sel_t'(ctrl_r[CTRL_SEL_LSB +: 2])) // R10
				SEL_EDGE_A: selVal = edgeA;
				SEL_EDGE_B: selVal = edgeB;
				SEL_DIFF:   selVal = VW'(edgeB - edgeA);
				default:    selVal = sumAB[VW:1];
			endcase
		end
		// R11
		monVal = ctrl_r[CTRL_MASTER] ? VW'(selVal - masterOffset) : selVal;
		condNxt[0] = (edgesFound < edgesNeeded) || (edgesFound == '0); // R04
		condNxt[1] = !condNxt[0] && (monVal < lower_r); // R05 R09
		condNxt[2] = !condNxt[0] && (monVal > upper_r); // R06 R09
		condNxt[3] = edgesFound < edgesExp_r; // R08
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cond_r   <= 4'h0;
			evalEn_r <= 1'b0;
		end else begin
			evalEn_r <= measValid;
			if (measValid) begin
				cond_r <= condNxt; // R13
			end
		end
	end

	// ****************************************************
	// switching outputs
	// ****************************************************
	logic [1:0] pinOutW;
	logic [1:0] pinOeW;
	for (genvar g = 0; g < 2; g++) begin : gOut
		lmso_out_stage uStage (
			.clock  (clock),
			.nrst   (nrst),
			.evalEn (evalEn_r),
			.src    (lmso_src_t'(ctrl_r[(g*4) +: 3])),
			.drv    (lmso_drv_t'(ctrl_r[(CTRL_DRV1_LSB + g*2) +: 2])),
			.cond   (cond_r),
			.active (active[g]),
			.pinOut (pinOutW[g]),
			.pinOe  (pinOeW[g])
		);
	end
	assign swOut = pinOutW;
	assign swOe  = pinOeW;

	// ****************************************************
	// interrupt status, read clears
	// ****************************************************
	logic rdStatus;
	logic [4:0] evt;
	assign rdStatus = s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_STATUS;
	assign evt = {cmdValid, evalEn_r ? {cond_r[3], cond_r[2], cond_r[1], cond_r[0]} : 4'h0};

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			status_r <= 5'h00;
			irq      <= 1'b0;
		end else begin
			// set wins over the read clear
			status_r <= (rdStatus ? 5'h00 : status_r) | evt;
			irq      <= |(((rdStatus ? 5'h00 : status_r) | evt) & mask_r);
		end
	end

	// ****************************************************
	// axi4-lite read path
	// ****************************************************
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= RESP_OKAY;
			case (s_axi_araddr)
				OFF_CTRL:     s_axi_rdata <= ctrl_r;
				OFF_LOWER:    s_axi_rdata <= 32'(lower_r);
				OFF_UPPER:    s_axi_rdata <= 32'(upper_r);
				OFF_EDGES:    s_axi_rdata <= 32'(edgesExp_r);
				OFF_NETMODE:  s_axi_rdata <= {30'h0, netBoot_r, netPending_r};
				OFF_STATUS:   s_axi_rdata <= {27'h0, status_r | evt};
				OFF_INTMASK:  s_axi_rdata <= {27'h0, mask_r};
				OFF_OUTSTATE: s_axi_rdata <= {24'h0, cond_r, swOe, active};
				OFF_CMDDATA:  s_axi_rdata <= {24'h0, cmdData_r};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule

// ===== lmso_top_tb.sv
// Purpose: self-checking bench for lmso_top
// Assumes: axi4-lite master tasks, pins judged at controller inputs
// Notes:   limits 10 and 20 throughout the output tests
`timescale 1ns/1ps
module lmso_top_tb;
	import lmso_pkg::*;
	logic clock, nrst, measValid, singleEdgeProg, cmdValid, netFieldbus, irq;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic signed [31:0] edgeA, edgeB, masterOffset;
	logic [7:0] edgesFound, edgesNeeded, cmdByte, s_axi_awaddr, s_axi_araddr;
	logic [1:0] swOut, swOe, s_axi_bresp, s_axi_rresp, pullUp, level;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, ce[5];
	int errors, cmp_count, va[5], fn[5], nd[5], sc[5], sa[5], sb[5], sx[5];
	lmso_top u_lmso_top (.clock, .nrst, .measValid, .singleEdgeProg, .edgeA, .edgeB,
		.masterOffset, .edgesFound, .edgesNeeded, .cmdValid, .cmdByte, .netFieldbus,
		.swOut, .swOe, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	lmso_ctrl_in u_lmso_ctrl_in (.swOut, .swOe, .pullUp, .level);
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// **********
	// bus tasks: handshakes seen before the edge that completes them
	// **********
	task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
		logic ta, tw, v;
		logic [1:0] r;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge clock);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			v = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clock);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end while (!v);
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, r});
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] e, logic [1:0] er);
		logic t, v;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge clock);
			t = s_axi_arvalid & s_axi_arready;
			v = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clock);
			if (t) s_axi_arvalid <= 1'b0;
		end while (!v);
		s_axi_rready <= 1'b0;
		chk("rdata", e, d);
		chk("rresp", {30'h0, er}, {30'h0, r});
	endtask
	task automatic meas(int a, int b, int f, int n);
		@(posedge clock);
		edgeA <= a;
		edgeB <= b;
		edgesFound <= 8'(f);
		edgesNeeded <= 8'(n);
		measValid <= 1'b1;
		@(posedge clock);
		measValid <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
	endtask
	// c is {edge count, meas error, upper, lower}
	function automatic logic act(int s, logic [3:0] c);
		case (s)
			0: return c[2];
			2: return c[0];
			3: return c[1];
			4: return c[0] | c[1];
			5: return c[3];
			default: return 1'b0;
		endcase
	endfunction
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		#100000;
		errors++;
		close_out();
	end
	initial begin
		nrst = 1'b0;
		{measValid, singleEdgeProg, cmdValid, cmdByte, edgeA, edgeB} = '0;
		{edgesFound, edgesNeeded, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		masterOffset = 32'sd3;
		pullUp = 2'b01;
		va = '{5, 15, 25, 5, 15};
		fn = '{2, 2, 2, 1, 1};
		nd = '{2, 2, 2, 2, 1};
		ce = '{4'h1, 4'h0, 4'h2, 4'hc, 4'h8};
		sc = '{32'ha000, 32'h2000, 32'h3000, 32'h1000, 32'h1000};
		sa = '{100, 100, 100, 100, 5};
		sb = '{112, 112, 112, 112, 15};
		sx = '{1, 0, 2, 2, 1};
		repeat (4) @(posedge clock);
		nrst <= 1'b1;
		rd(OFF_CTRL, CTRL_RST, RESP_OKAY);
		rd(OFF_LOWER, LOWER_RST, RESP_OKAY);
		rd(OFF_UPPER, UPPER_RST, RESP_OKAY);
		rd(OFF_EDGES, {24'h0, EDGES_RST}, RESP_OKAY);
		rd(8'h30, 32'h0, RESP_SLVERR);
		wr(OFF_STATUS, 32'h1f, RESP_SLVERR);
		$display("test registers done");
		wr(OFF_LOWER, 32'd10, RESP_OKAY);
		wr(OFF_UPPER, 32'd20, RESP_OKAY);
		// out1 push-pull, out2 inverted push-pull, same source
		for (int s = 0; s < 6; s++) begin
			wr(OFF_CTRL, 32'h0e00 | 32'(s << 4) | 32'(s), RESP_OKAY);
			for (int c = 0; c < 5; c++) begin
				meas(va[c], 0, fn[c], nd[c]);
				chk("out1", {31'h0, act(s, ce[c])}, {31'h0, level[0]});
				chk("out2", {31'h0, !act(s, ce[c])}, {31'h0, level[1]});
			end
		end
		$display("test sources done");
		wr(OFF_CTRL, 32'h0422, RESP_OKAY);
		for (int c = 0; c < 2; c++) begin
			meas(c ? 15 : 5, 0, 2, 2);
			chk("drive", c ? 32'h1 : 32'h2, {30'h0, level});
		end
		$display("test drive done");
		for (int r = 0; r < 5; r++) begin
			wr(OFF_CTRL, 32'h0a32 | sc[r], RESP_OKAY);
			singleEdgeProg <= (r == 4);
			meas(sa[r], sb[r], 2, 2);
			chk("select", sx[r], {30'h0, level});
		end
		$display("test select done");
		rd(OFF_OUTSTATE, 32'h2d, RESP_OKAY);
		rd(OFF_STATUS, 32'h0f, RESP_OKAY);
		wr(OFF_NETMODE, 32'h1, RESP_OKAY);
		rd(OFF_NETMODE, 32'h1, RESP_OKAY);
		chk("mode", 32'h0, {31'h0, netFieldbus});
		// restart: the stored mode must now be the running one
		@(posedge clock);
		nrst <= 1'b0;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		rd(OFF_NETMODE, 32'h3, RESP_OKAY);
		chk("modeRestart", 32'h1, {31'h0, netFieldbus});
		@(posedge clock);
		cmdByte <= 8'h5a;
		cmdValid <= 1'b1;
		@(posedge clock);
		cmdValid <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		chk("irqMasked", 32'h0, {31'h0, irq});
		wr(OFF_INTMASK, 32'h10, RESP_OKAY);
		repeat (2) @(posedge clock);
		#1;
		chk("irq", 32'h1, {31'h0, irq});
		rd(OFF_CMDDATA, 32'h5a, RESP_OKAY);
		rd(OFF_STATUS, 32'h10, RESP_OKAY);
		repeat (2) @(posedge clock);
		#1;
		chk("irqClear", 32'h0, {31'h0, irq});
		$display("test mode and command done");
		close_out();
	end
endmodule
bind lmso_top lmso_checker u_lmso_checker (.clock, .nrst, .measValid, .netFieldbus, .swOut,
	.swOe, .irq, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
